/* File: logic/cmu_pkg.sv */
// Purpose: shared constants and types of the conditional move unit
// Assumes: 32-bit AXI4-Lite register port, one-cycle execute stage
// Notes:   control and status bits live in two registers at 0x00 and 0x04
package cmu_pkg;

    localparam logic [7:0]  CMU_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  CMU_STATUS_OFS   = 8'h04;
    localparam int          CMU_WIDE_BIT     = 0;
    localparam int          CMU_F64_BIT      = 1;
    localparam int          CMU_REV6_BIT     = 2;
    localparam int          CMU_CU1_BIT      = 3;
    localparam int          CMU_CTRL_W       = 4;
    localparam logic [3:0]  CMU_CTRL_RST     = 4'ha;
    localparam int          CMU_MOVE_CNT_LSB = 0;
    localparam int          CMU_EXC_CNT_LSB  = 16;
    localparam int          CMU_LAST_EXC_LSB = 24;
    localparam logic [1:0]  CMU_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  CMU_RESP_DECERR  = 2'h3;

    typedef enum logic [2:0] {
        CMU_OP_NONE    = 3'b000,
        CMU_OP_MOV_FPR = 3'b001,
        CMU_OP_GPR_F   = 3'b010,
        CMU_OP_GPR_T   = 3'b011,
        CMU_OP_GPR_NZ  = 3'b100,
        CMU_OP_FPR_F   = 3'b101,
        CMU_OP_FPR_T   = 3'b110,
        CMU_OP_FPR_NZ  = 3'b111
    } cmu_op_t;

    typedef enum logic [1:0] {
        CMU_FMT_S    = 2'b00,
        CMU_FMT_D    = 2'b01,
        CMU_FMT_PAIR = 2'b10,
        CMU_FMT_RSVD = 2'b11
    } cmu_fmt_t;

    typedef enum logic [1:0] {
        CMU_EXC_NONE   = 2'b00,
        CMU_EXC_CPU    = 2'b01,
        CMU_EXC_RI     = 2'b10,
        CMU_EXC_UNIMPL = 2'b11
    } cmu_exc_t;

    typedef struct packed {
        logic        valid;
        cmu_op_t     op;
        cmu_fmt_t    fmt;
        logic [2:0]  cc;
        logic [4:0]  dest;
        logic [31:0] gen_source;
        logic [31:0] gen_test_register;
        logic [63:0] float_source;
        logic [63:0] float_destination;
    } cmu_issue_t;

    typedef struct packed {
        logic        valid;
        logic        gpr_we;
        logic        fpr_we;
        logic [1:0]  half_we;
        logic [4:0]  dest;
        logic [63:0] data;
        logic        exc_valid;
        cmu_exc_t    exc;
    } cmu_result_t;

    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [3:0]  ctrl;
        logic [15:0] move_cnt;
        logic [7:0]  exc_cnt;
        cmu_exc_t    last_exc;
        cmu_result_t res;
    } cmu_state_t;

endpackage : cmu_pkg

/* File: logic/cmu_move_unit.sv */
// Purpose: execute stage for plain and conditional register moves
// Assumes: issue inputs and condition codes synchronous to aclk
// Notes:   result appears one edge after issue; no stall, no buffering
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module cmu_move_unit (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    input  wire cmu_pkg::cmu_issue_t  issue,
    input  wire logic [7:0]           fp_cond_codes,
    output cmu_pkg::cmu_result_t      result
);

    cmu_pkg::cmu_state_t s_r;
    cmu_pkg::cmu_state_t s_nxt;

    logic                wr_fire;
    logic                cond_lo;
    logic                cond_hi;
    logic                test_lo;
    logic                test_hi;
    logic                take_lo;
    logic                take_hi;
    logic                is_gpr_op;
    logic                is_fpr_op;
    logic                mode_ok;
    cmu_pkg::cmu_exc_t   exc;
    logic [31:0]         status_word;
    logic [2:0]          cc_hi;

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready  = s_r.wready;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign result        = s_r.res;

    always_comb
    begin
        status_word = 32'h0;
        status_word[cmu_pkg::CMU_MOVE_CNT_LSB +: 16] = s_r.move_cnt;
        status_word[cmu_pkg::CMU_EXC_CNT_LSB +: 8]   = s_r.exc_cnt;
        status_word[cmu_pkg::CMU_LAST_EXC_LSB +: 2]  = s_r.last_exc;
    end

    // index 7 wraps to 0; result then undefined by contract
    assign cc_hi   = issue.cc + 3'h1;
    assign cond_lo = fp_cond_codes[issue.cc];
    assign cond_hi = fp_cond_codes[cc_hi];
    assign is_gpr_op = (issue.op == cmu_pkg::CMU_OP_GPR_F) ||
                       (issue.op == cmu_pkg::CMU_OP_GPR_T) ||
                       (issue.op == cmu_pkg::CMU_OP_GPR_NZ);
    assign is_fpr_op = issue.valid && !is_gpr_op && (issue.op != cmu_pkg::CMU_OP_NONE);
    // paired moves only defined on a wide unit in wide mode
    assign mode_ok = s_r.ctrl[cmu_pkg::CMU_F64_BIT] && s_r.ctrl[cmu_pkg::CMU_WIDE_BIT];

    // exception decode and per-half selection
    always_comb
    begin
        exc     = cmu_pkg::CMU_EXC_NONE;
        test_lo = 1'b0;
        test_hi = 1'b0;
        take_lo = 1'b0;
        take_hi = 1'b0;
        case (issue.op)
            cmu_pkg::CMU_OP_GPR_F:
            begin
                test_lo = !cond_lo;
            end
            cmu_pkg::CMU_OP_GPR_T:
            begin
                test_lo = cond_lo;
            end
            cmu_pkg::CMU_OP_GPR_NZ:
            begin
                test_lo = (issue.gen_test_register != 32'h0);
            end
            cmu_pkg::CMU_OP_MOV_FPR:
            begin
                test_lo = 1'b1;
                test_hi = 1'b1;
            end
            cmu_pkg::CMU_OP_FPR_F:
            begin
                test_lo = !cond_lo;
                test_hi = (issue.fmt == cmu_pkg::CMU_FMT_PAIR) ? !cond_hi : !cond_lo;
            end
            cmu_pkg::CMU_OP_FPR_T:
            begin
                test_lo = cond_lo;
                test_hi = (issue.fmt == cmu_pkg::CMU_FMT_PAIR) ? cond_hi : cond_lo;
            end
            cmu_pkg::CMU_OP_FPR_NZ:
            begin
                test_lo = (issue.gen_test_register != 32'h0);
                test_hi = test_lo;
            end
            default:
            begin
                test_lo = 1'b0;
                test_hi = 1'b0;
            end
        endcase
        if (!issue.valid || issue.op == cmu_pkg::CMU_OP_NONE)
        begin
            exc = cmu_pkg::CMU_EXC_NONE;
        end
        else if (issue.op == cmu_pkg::CMU_OP_GPR_NZ)
        begin
            // the nonzero gpr move has no coprocessor dependency
            if (s_r.ctrl[cmu_pkg::CMU_REV6_BIT])
                exc = cmu_pkg::CMU_EXC_RI;
        end
        else if (s_r.ctrl[cmu_pkg::CMU_REV6_BIT] &&
                 (issue.op != cmu_pkg::CMU_OP_MOV_FPR || issue.fmt == cmu_pkg::CMU_FMT_PAIR))
        begin
            exc = cmu_pkg::CMU_EXC_RI;
        end
        else if (!s_r.ctrl[cmu_pkg::CMU_CU1_BIT])
        begin
            exc = cmu_pkg::CMU_EXC_CPU;
        end
        else if (is_fpr_op && issue.fmt == cmu_pkg::CMU_FMT_RSVD)
        begin
            exc = cmu_pkg::CMU_EXC_RI;
        end
        else if (is_fpr_op && issue.fmt == cmu_pkg::CMU_FMT_PAIR && !mode_ok)
        begin
            exc = cmu_pkg::CMU_EXC_UNIMPL;
        end
        if (issue.valid && exc == cmu_pkg::CMU_EXC_NONE)
        begin
            take_lo = test_lo;
            // single format owns only the low word
            take_hi = test_hi && is_fpr_op && (issue.fmt != cmu_pkg::CMU_FMT_S);
        end
    end

    assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;

    always_comb
    begin
        s_nxt = s_r;
        // write address and data taken independently, in either order
        if (s_axi_awvalid && s_r.awready)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready)
        begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (wr_fire)
        begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = cmu_pkg::CMU_RESP_OKAY;
            if (s_r.aw_addr == cmu_pkg::CMU_CTRL_OFS)
            begin
                if (s_r.w_strb[0])
                    s_nxt.ctrl = s_r.w_data[cmu_pkg::CMU_CTRL_W-1:0];
            end
            else if (s_r.aw_addr != cmu_pkg::CMU_STATUS_OFS)
            begin
                s_nxt.bresp = cmu_pkg::CMU_RESP_DECERR;
            end
        end
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_r.arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = cmu_pkg::CMU_RESP_OKAY;
            s_nxt.rdata  = 32'h0;
            if (s_axi_araddr == cmu_pkg::CMU_CTRL_OFS)
                s_nxt.rdata[cmu_pkg::CMU_CTRL_W-1:0] = s_r.ctrl;
            else if (s_axi_araddr == cmu_pkg::CMU_STATUS_OFS)
                s_nxt.rdata = status_word;
            else
                s_nxt.rresp = cmu_pkg::CMU_RESP_DECERR;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // execute: a failed test drops the write, so no stale forward
        s_nxt.res.valid     = issue.valid;
        s_nxt.res.dest      = issue.dest;
        s_nxt.res.gpr_we    = is_gpr_op && take_lo;
        s_nxt.res.fpr_we    = is_fpr_op && (take_lo || take_hi);
        s_nxt.res.half_we   = is_fpr_op ? {take_hi, take_lo} : {1'b0, is_gpr_op && take_lo};
        s_nxt.res.exc_valid = (exc != cmu_pkg::CMU_EXC_NONE);
        // only unimplemented-op is an fp exception; never an ieee one
        s_nxt.res.exc       = exc;
        if (is_gpr_op)
            s_nxt.res.data = {32'h0, issue.gen_source};
        else
            // untaken half keeps old contents
            s_nxt.res.data = {take_hi ? issue.float_source[63:32]
                                      : issue.float_destination[63:32],
                              take_lo ? issue.float_source[31:0]
                                      : issue.float_destination[31:0]};
        if (s_nxt.res.gpr_we || s_nxt.res.fpr_we)
            s_nxt.move_cnt = s_r.move_cnt + 16'h1;
        if (exc != cmu_pkg::CMU_EXC_NONE)
        begin
            s_nxt.exc_cnt  = s_r.exc_cnt + 8'h1;
            s_nxt.last_exc = exc;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r          <= '0;
            s_r.ctrl     <= cmu_pkg::CMU_CTRL_RST;
            s_r.awready  <= 1'b1;
            s_r.wready   <= 1'b1;
            s_r.arready  <= 1'b1;
            s_r.last_exc <= cmu_pkg::CMU_EXC_NONE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_gpr_false_move: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_GPR_F && !fp_cond_codes[issue.cc]
        && s_r.ctrl == 4'ha
        |=> result.gpr_we && result.data[31:0] == $past(issue.gen_source))
        else $error("gpr false move did not write");

    a_gpr_true_move: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_GPR_T && s_r.ctrl == 4'ha
        |=> result.gpr_we == $past(fp_cond_codes[issue.cc]))
        else $error("gpr true move write mismatch");

    a_gpr_nonzero_move: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_GPR_NZ && !s_r.ctrl[2]
        |=> result.gpr_we == ($past(issue.gen_test_register) != 32'h0))
        else $error("nonzero move write mismatch");

    a_fpr_keep_old: assert property (
        result.fpr_we && !result.half_we[1]
        |-> result.data[63:32] == $past(issue.float_destination[63:32]))
        else $error("untaken half not kept");

    a_pair_false_hi: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_FPR_F && issue.fmt == cmu_pkg::CMU_FMT_PAIR
        && s_r.ctrl == 4'hb
        |=> result.half_we == ~$past({fp_cond_codes[cc_hi], fp_cond_codes[issue.cc]}))
        else $error("paired false merge wrong");

    a_pair_true_halves: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_FPR_T && issue.fmt == cmu_pkg::CMU_FMT_PAIR
        && s_r.ctrl == 4'hb
        |=> result.half_we == $past({fp_cond_codes[cc_hi], fp_cond_codes[issue.cc]}))
        else $error("paired true merge wrong");

    a_pair_mode_unimpl: assert property (
        is_fpr_op && issue.fmt == cmu_pkg::CMU_FMT_PAIR && s_r.ctrl == 4'ha
        |=> result.exc == cmu_pkg::CMU_EXC_UNIMPL && !result.fpr_we)
        else $error("paired move ran without wide mode");

    a_cpu_unusable: assert property (
        issue.valid && issue.op != cmu_pkg::CMU_OP_NONE
        && issue.op != cmu_pkg::CMU_OP_GPR_NZ && s_r.ctrl[3:2] == 2'b00
        |=> result.exc == cmu_pkg::CMU_EXC_CPU)
        else $error("coprocessor unusable not raised");

    a_plain_pair_copy: assert property (
        issue.valid && issue.op == cmu_pkg::CMU_OP_MOV_FPR
        && issue.fmt == cmu_pkg::CMU_FMT_PAIR && s_r.ctrl == 4'hb
        |=> result.fpr_we && result.data == $past(issue.float_source))
        else $error("plain paired move not copied");

    a_rev6_reserved: assert property (
        issue.valid && s_r.ctrl[2] && issue.op != cmu_pkg::CMU_OP_NONE
        && issue.op != cmu_pkg::CMU_OP_MOV_FPR
        |=> result.exc == cmu_pkg::CMU_EXC_RI && !result.gpr_we && !result.fpr_we)
        else $error("removed move not reserved");

    a_fail_no_write: assert property (
        result.exc_valid |-> !result.gpr_we && !result.fpr_we && result.half_we == 2'b00)
        else $error("write with exception");

    a_axi_b_after_w: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> ##1 s_axi_bvalid)
        else $error("write response late");

endmodule : cmu_move_unit

`default_nettype wire

/* File: test/cmu_testbench.sv */
// Purpose: self-checking bench for the conditional move unit
// Assumes: one-cycle result latency, AXI4-Lite control registers
// Notes:   a cycle model predicts each result from the issue stream
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                 s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic                 s_axi_arready, s_axi_rvalid, s_axi_rready, pend;
    logic [7:0]           s_axi_awaddr, s_axi_araddr, fp_cond_codes, exc_cnt_m;
    logic [31:0]          s_axi_wdata, s_axi_rdata;
    logic [3:0]           s_axi_wstrb, ctrl_m;
    logic [1:0]           s_axi_bresp, s_axi_rresp, exp_m;
    cmu_pkg::cmu_issue_t  issue;
    cmu_pkg::cmu_result_t result, exp_r;
    cmu_pkg::cmu_exc_t    last_exc_m;
    logic [15:0]          move_cnt_m;
    int                   err_total, checks_done, cyc;

    cmu_move_unit uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .issue,
        .fp_cond_codes, .result);

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task wrap_up();
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    // expected outcome of one issue under the current control bits
    function void model(input cmu_pkg::cmu_issue_t i, input logic [7:0] c,
                        output cmu_pkg::cmu_result_t e, output logic [1:0] m);
        logic              fp, lo, hi;
        cmu_pkg::cmu_exc_t x;
        fp = i.op inside {cmu_pkg::CMU_OP_MOV_FPR, cmu_pkg::CMU_OP_FPR_F,
                          cmu_pkg::CMU_OP_FPR_T, cmu_pkg::CMU_OP_FPR_NZ};
        e = '0;
        m = 2'b00;
        e.valid = 1'b1;
        e.dest = i.dest;
        x = cmu_pkg::CMU_EXC_NONE;
        lo = 1'b1;
        hi = 1'b1;
        if (ctrl_m[cmu_pkg::CMU_REV6_BIT] && (i.op != cmu_pkg::CMU_OP_MOV_FPR
            || i.fmt == cmu_pkg::CMU_FMT_PAIR))
            x = cmu_pkg::CMU_EXC_RI;
        else if (!ctrl_m[cmu_pkg::CMU_CU1_BIT] && i.op != cmu_pkg::CMU_OP_GPR_NZ)
            x = cmu_pkg::CMU_EXC_CPU;
        else if (fp && i.fmt == cmu_pkg::CMU_FMT_RSVD)
            x = cmu_pkg::CMU_EXC_RI;
        else if (fp && i.fmt == cmu_pkg::CMU_FMT_PAIR && !(ctrl_m[cmu_pkg::CMU_F64_BIT]
                 && ctrl_m[cmu_pkg::CMU_WIDE_BIT]))
            x = cmu_pkg::CMU_EXC_UNIMPL;
        case (i.op)
            cmu_pkg::CMU_OP_GPR_F, cmu_pkg::CMU_OP_FPR_F:
            begin
                lo = ~c[i.cc];
                hi = ~c[i.cc + 3'd1];
            end
            cmu_pkg::CMU_OP_GPR_T, cmu_pkg::CMU_OP_FPR_T:
            begin
                lo = c[i.cc];
                hi = c[i.cc + 3'd1];
            end
            cmu_pkg::CMU_OP_GPR_NZ, cmu_pkg::CMU_OP_FPR_NZ:
            begin
                lo = |i.gen_test_register;
                hi = lo;
            end
            default: ;
        endcase
        if (i.fmt != cmu_pkg::CMU_FMT_PAIR)
            hi = (i.fmt == cmu_pkg::CMU_FMT_D) ? lo : 1'b0;
        if (x != cmu_pkg::CMU_EXC_NONE)
        begin
            e.exc_valid = 1'b1;
            e.exc = x;
        end
        else if (!fp)
        begin
            e.gpr_we = lo;
            e.half_we = {1'b0, lo};
            e.data = {32'h0, i.gen_source};
            m = {lo, lo};
        end
        else
        begin
            e.fpr_we = hi | lo;
            e.half_we = {hi, lo};
            e.data = {hi ? i.float_source[63:32] : i.float_destination[63:32],
                      lo ? i.float_source[31:0] : i.float_destination[31:0]};
            m = (i.fmt == cmu_pkg::CMU_FMT_PAIR && (hi | lo)) ? 2'b11 : {hi, lo};
        end
    endfunction : model

    always @(posedge aclk)
    begin
        cyc++;
        model(issue, fp_cond_codes, exp_r, exp_m);
        pend = aresetn && issue.valid;
        if (pend && (exp_r.gpr_we || exp_r.fpr_we))
            move_cnt_m++;
        if (pend && exp_r.exc_valid)
        begin
            exc_cnt_m++;
            last_exc_m = exp_r.exc;
        end
        if (cyc > 3000)
        begin
            err_total++;
            wrap_up();
        end
    end

    always @(negedge aclk)
    begin
        chk("result_valid", 64'(pend), 64'(result.valid));
        if (pend)
        begin
            chk("write_enables", 64'({exp_r.gpr_we, exp_r.fpr_we, exp_r.half_we, exp_r.exc_valid}),
                64'({result.gpr_we, result.fpr_we, result.half_we, result.exc_valid}));
            if (exp_r.exc_valid)
                chk("exception", 64'(exp_r.exc), 64'(result.exc));
            if (exp_r.gpr_we || exp_r.fpr_we)
                chk("dest", 64'(exp_r.dest), 64'(result.dest));
            chk("data", {{32{exp_m[1]}}, {32{exp_m[0]}}} & exp_r.data,
                {{32{exp_m[1]}}, {32{exp_m[0]}}} & result.data);
        end
    end

    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_bvalid)
                break;
            if (s_axi_awready && !ad)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd)
            begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        chk("write_resp", 64'(er), 64'(s_axi_bresp));
        if (er == cmu_pkg::CMU_RESP_OKAY && a == cmu_pkg::CMU_CTRL_OFS && s[0])
            ctrl_m = d[3:0];
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
                input logic [1:0] er);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_rvalid)
                break;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("read_resp", 64'(er), 64'(s_axi_rresp));
        chk("read_data", 64'(e & mk), 64'(s_axi_rdata & mk));
    endtask : axi_rd

    // every op but none, gpr ops in single format only, all four condition pairs, issued back to back
    task run_all();
        cmu_pkg::cmu_issue_t x;
        for (int o = 1; o < 8; o++)
            for (int f = 0; f < 4; f++)
                for (int k = 0; k < 4; k++)
                begin
                    if (o >= 2 && o <= 4 && f != 0)
                        continue;
                    x.valid = 1'b1;
                    x.op = cmu_pkg::cmu_op_t'(o);
                    x.fmt = cmu_pkg::cmu_fmt_t'(f);
                    x.cc = 3'(2 * k);
                    x.dest = 5'(cyc);
                    x.gen_source = 32'h1357_9bdf ^ 32'(cyc);
                    x.gen_test_register = (k == 2) ? 32'h0 : ((k == 1) ? 32'h8000_0000 : 32'h1);
                    x.float_source = {32'hc0de_0000 ^ 32'(cyc), 32'h0000_abcd ^ 32'(cyc)};
                    x.float_destination = 64'h0f0f_1111_f0f0_2222;
                    @(posedge aclk);
                    issue <= x;
                    fp_cond_codes <= (8'(k % 2) << (2 * k)) | (8'(k / 2) << (2 * k + 1));
                end
        @(posedge aclk);
        issue.valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : run_all

    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        issue = '0;
        fp_cond_codes = 8'h00;
        {err_total, checks_done, cyc} = '0;
        ctrl_m = cmu_pkg::CMU_CTRL_RST;
        exc_cnt_m = 8'h00;
        move_cnt_m = 16'h0;
        last_exc_m = cmu_pkg::CMU_EXC_NONE;
        pend = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(cmu_pkg::CMU_CTRL_OFS, 32'ha, 32'hf, cmu_pkg::CMU_RESP_OKAY);
        axi_rd(cmu_pkg::CMU_STATUS_OFS, 32'h0, 32'h03ff_ffff, cmu_pkg::CMU_RESP_OKAY);
        axi_wr(cmu_pkg::CMU_CTRL_OFS, 32'hb, 4'hf, cmu_pkg::CMU_RESP_OKAY);
        run_all();
        axi_wr(cmu_pkg::CMU_CTRL_OFS, 32'h0, 4'he, cmu_pkg::CMU_RESP_OKAY);
        axi_rd(cmu_pkg::CMU_CTRL_OFS, 32'hb, 32'hf, cmu_pkg::CMU_RESP_OKAY);
        axi_wr(cmu_pkg::CMU_STATUS_OFS, 32'hffff_ffff, 4'hf, cmu_pkg::CMU_RESP_OKAY);
        axi_wr(8'h08, 32'h1, 4'hf, cmu_pkg::CMU_RESP_DECERR);
        axi_rd(8'h08, 32'h0, 32'h0, cmu_pkg::CMU_RESP_DECERR);
        axi_wr(cmu_pkg::CMU_CTRL_OFS, 32'ha, 4'hf, cmu_pkg::CMU_RESP_OKAY);
        run_all();
        axi_wr(cmu_pkg::CMU_CTRL_OFS, 32'h3, 4'hf, cmu_pkg::CMU_RESP_OKAY);
        run_all();
        axi_wr(cmu_pkg::CMU_CTRL_OFS, 32'hf, 4'hf, cmu_pkg::CMU_RESP_OKAY);
        run_all();
        axi_rd(cmu_pkg::CMU_STATUS_OFS, {6'h0, 2'(last_exc_m), exc_cnt_m, move_cnt_m},
               32'h03ff_ffff, cmu_pkg::CMU_RESP_OKAY);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
